// >>> rtl/compare_skip_bcd_decrement_exec.sv
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module compare_skip_bcd_decrement_exec
  import exec_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  // Instruction from decode stage
  input  wire logic [15:0] INSTR,
  input  wire logic        INSTR_VALID,
  input  wire logic        NEXT_TWO_WORD,
  input  wire logic        EXT_SET_EN,
  // Core state
  input  wire logic [3:0]  BANK_SEL,
  input  wire logic [11:0] INDEX_BASE,
  input  wire logic [7:0]  WREG,
  input  wire logic [4:0]  FLAGS_IN,
  // Data memory
  output logic      [11:0] MEM_ADDR,
  output logic             MEM_RD,
  input  wire logic [7:0]  MEM_RDATA,
  output logic             MEM_WR,
  output logic      [7:0]  MEM_WDATA,
  // Accumulator and flag writes
  output logic             WREG_WR,
  output logic      [7:0]  WREG_WDATA,
  output logic      [4:0]  FLAGS_WR,
  output logic      [4:0]  FLAGS_OUT,
  // Sequencing
  output logic      [3:0]  QPHASE,
  output logic             SKIP_FLUSH,
  output logic             NOP_ACTIVE,
  output logic             BUSY,
  output logic             DONE
);

  state_t      state;
  state_t      next_state;
  op_t         op_q;
  logic [15:0] instr_q;
  logic        take_skip;
  logic        skip_two;
  logic [3:0]  nop_cnt;
  logic [7:0]  alu_operand;
  logic [7:0]  alu_result;
  logic [4:0]  alu_flags;
  logic [4:0]  alu_mask;
  logic        alu_less;
  logic        alu_greater;
  logic        is_compare;
  logic        next_skip;

  assign is_compare  = (op_q == OP_LESS) || (op_q == OP_GREATER);
  // Accumulator is the operand for decimal adjust, memory otherwise
  assign alu_operand = (op_q == OP_DADJ) ? WREG : MEM_RDATA;
  assign next_skip   = ((op_q == OP_LESS) && alu_less) ||
                       ((op_q == OP_GREATER) && alu_greater);

  exec_alu u_alu (
    .op        (op_q),
    .operand   (alu_operand),
    .acc       (WREG),
    .flags_in  (FLAGS_IN),
    .result    (alu_result),
    .flags_out (alu_flags),
    .flag_mask (alu_mask),
    .less      (alu_less),
    .greater   (alu_greater)
  );

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (INSTR_VALID && decode_op(INSTR) != OP_NONE) begin
          next_state = ST_Q1;
        end
      end
      ST_Q1: begin
        next_state = ST_Q2;
      end
      ST_Q2: begin
        next_state = ST_Q3;
      end
      ST_Q3: begin
        next_state = ST_Q4;
      end
      ST_Q4: begin
        next_state = take_skip ? ST_NOP : ST_IDLE;
      end
      ST_NOP: begin
        if (nop_cnt == 4'h1) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
    end else if (CE) begin
      state <= next_state;
    end
  end

  // Instruction capture
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      op_q    <= OP_NONE;
      instr_q <= 16'h0000;
    end else if (CE && state == ST_IDLE && INSTR_VALID) begin
      op_q    <= decode_op(INSTR);
      instr_q <= INSTR;
    end
  end

  // Address formed in decode quarter, read strobe in the read quarter
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_ADDR <= 12'h000;
      MEM_RD   <= 1'b0;
    end else if (CE) begin
      if (state == ST_Q1) begin
        MEM_ADDR <= eff_addr(instr_q[BIT_A], instr_q[7:0], BANK_SEL, EXT_SET_EN, INDEX_BASE);
      end
      MEM_RD <= (state == ST_Q1) && (op_q != OP_DADJ);
    end
  end

  // Skip decision in the process quarter; flags never touched by compares
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      take_skip <= 1'b0;
      skip_two  <= 1'b0;
    end else if (CE && state == ST_Q3) begin
      take_skip <= next_skip;
      skip_two  <= NEXT_TWO_WORD;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      nop_cnt <= 4'h0;
    end else if (CE) begin
      if (state == ST_Q4) begin
        nop_cnt <= skip_two ? NOP_QUARTERS_2 : NOP_QUARTERS_1;
      end else if (state == ST_NOP) begin
        nop_cnt <= nop_cnt - 4'h1;
      end
    end
  end

  // Write-back strobes stand in the write quarter only
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_WR     <= 1'b0;
      MEM_WDATA  <= 8'h00;
      WREG_WR    <= 1'b0;
      WREG_WDATA <= 8'h00;
      FLAGS_WR   <= MASK_NONE;
      FLAGS_OUT  <= 5'h00;
    end else if (CE) begin
      MEM_WR   <= (state == ST_Q3) && (op_q == OP_DEC) && instr_q[BIT_D];
      WREG_WR  <= (state == ST_Q3) && ((op_q == OP_DADJ) ||
                  ((op_q == OP_DEC) && !instr_q[BIT_D]));
      FLAGS_WR <= (state == ST_Q3) ? alu_mask : MASK_NONE;
      if (state == ST_Q3) begin
        MEM_WDATA  <= alu_result;
        WREG_WDATA <= alu_result;
        FLAGS_OUT  <= alu_flags;
      end
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      QPHASE     <= 4'h0;
      SKIP_FLUSH <= 1'b0;
      NOP_ACTIVE <= 1'b0;
      BUSY       <= 1'b0;
      DONE       <= 1'b0;
    end else if (CE) begin
      QPHASE     <= {next_state == ST_Q4, next_state == ST_Q3, next_state == ST_Q2, next_state == ST_Q1};
      SKIP_FLUSH <= (state == ST_Q3) && next_skip;
      NOP_ACTIVE <= next_state == ST_NOP;
      BUSY       <= next_state != ST_IDLE;
      DONE       <= (state != ST_IDLE) && (next_state == ST_IDLE);
    end
  end

  // Checks
  property p_decode;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (state == ST_IDLE && INSTR_VALID && decode_op(INSTR) != OP_NONE) |=> state == ST_Q1 ##3 state == ST_Q4;
  endproperty
  a_decode: assert property (p_decode) else $error("decode did not start a quarter sequence");

  property p_less_skip;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (state == ST_Q3 && op_q == OP_LESS) |=> (SKIP_FLUSH == ($past(MEM_RDATA) < $past(WREG))) && FLAGS_WR == MASK_NONE;
  endproperty
  a_less_skip: assert property (p_less_skip) else $error("skip-if-less decision wrong");

  property p_greater_skip;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (state == ST_Q3 && op_q == OP_GREATER) |=> SKIP_FLUSH == ($past(MEM_RDATA) > $past(WREG));
  endproperty
  a_greater_skip: assert property (p_greater_skip) else $error("skip-if-greater decision wrong");

  property p_skip_one;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (SKIP_FLUSH && !skip_two) |=> NOP_ACTIVE [*4] ##1 !NOP_ACTIVE;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("single skip not one nop cycle");

  property p_skip_two;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (SKIP_FLUSH && skip_two) |=> NOP_ACTIVE [*8] ##1 !NOP_ACTIVE;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two-word skip not two nop cycles");

  property p_nop_quiet;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (NOP_ACTIVE || (QPHASE[3] && is_compare)) |-> !MEM_WR && !WREG_WR && FLAGS_WR == MASK_NONE && !MEM_RD;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("write during nop or compare");

  property p_bank;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (MEM_RD && instr_q[BIT_A]) |-> MEM_ADDR == {$past(BANK_SEL), instr_q[7:0]};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");

  property p_indexed;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (MEM_RD && !instr_q[BIT_A] && $past(EXT_SET_EN) && instr_q[7:0] <= ACCESS_LIMIT)
      |-> MEM_ADDR == 12'($past(INDEX_BASE) + {4'h0, instr_q[7:0]});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed offset address wrong");

  property p_dadj;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (state == ST_Q3 && op_q == OP_DADJ) |=> WREG_WR && !MEM_WR && FLAGS_WR == MASK_C ##1 DONE;
  endproperty
  a_dadj: assert property (p_dadj) else $error("decimal adjust write or timing wrong");

  property p_dadj_valid;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (state == ST_Q3 && op_q == OP_DADJ && WREG[3:0] <= BCD_LIMIT && WREG[7:4] <= BCD_LIMIT &&
     !FLAGS_IN[FLAG_DC] && !FLAGS_IN[FLAG_C]) |=> WREG_WDATA == $past(WREG) && !FLAGS_OUT[FLAG_C];
  endproperty
  a_dadj_valid: assert property (p_dadj_valid) else $error("valid BCD value altered");

  property p_dec;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (state == ST_Q3 && op_q == OP_DEC) |=>
      (instr_q[BIT_D] ? (MEM_WR && !WREG_WR && MEM_WDATA == 8'($past(MEM_RDATA) - 8'h01))
                      : (WREG_WR && !MEM_WR && WREG_WDATA == 8'($past(MEM_RDATA) - 8'h01)));
  endproperty
  a_dec: assert property (p_dec) else $error("decrement destination wrong");

  property p_dec_flags;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (state == ST_Q3 && op_q == OP_DEC) |=>
      FLAGS_WR == MASK_ALL && FLAGS_OUT[FLAG_Z] == ($past(MEM_RDATA) == 8'h01) ##1 DONE && !BUSY;
  endproperty
  a_dec_flags: assert property (p_dec_flags) else $error("decrement flags or length wrong");

  property p_qphase_walk;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    QPHASE[0] |=> QPHASE[1] ##1 QPHASE[2] ##1 QPHASE[3];
  endproperty
  a_qphase_walk: assert property (p_qphase_walk) else $error("quarter phases out of order");

  property p_read_q2;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    MEM_RD |-> QPHASE[1] && op_q != OP_DADJ;
  endproperty
  a_read_q2: assert property (p_read_q2) else $error("register read outside read quarter");

  property p_write_q4;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (MEM_WR || WREG_WR || FLAGS_WR != MASK_NONE) |-> QPHASE[3] && !is_compare;
  endproperty
  a_write_q4: assert property (p_write_q4) else $error("write outside write quarter or by compare");

  property p_flush_compare;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    SKIP_FLUSH |-> QPHASE[3] && is_compare;
  endproperty
  a_flush_compare: assert property (p_flush_compare) else $error("flush not from a compare");

  property p_no_skip_done;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (QPHASE[3] && !SKIP_FLUSH) |=> DONE && !NOP_ACTIVE;
  endproperty
  a_no_skip_done: assert property (p_no_skip_done) else $error("unskipped instruction not one cycle");

  property p_done_pulse;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    DONE |-> !BUSY ##1 !DONE;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single idle pulse");

  property p_dec_rest;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (state == ST_Q3 && op_q == OP_DEC) |=>
      FLAGS_OUT[FLAG_C] == ($past(MEM_RDATA) != 8'h00) &&
      FLAGS_OUT[FLAG_DC] == (($past(MEM_RDATA) & 8'h0F) != 8'h00) &&
      FLAGS_OUT[FLAG_OV] == ($past(MEM_RDATA) == OV_EDGE) &&
      FLAGS_OUT[FLAG_N] == ($past(MEM_RDATA) == 8'h00 || $past(MEM_RDATA) > OV_EDGE);
  endproperty
  a_dec_rest: assert property (p_dec_rest) else $error("decrement carry, overflow or sign wrong");

  property p_dadj_carry;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (state == ST_Q3 && op_q == OP_DADJ && FLAGS_IN[FLAG_C]) |=> FLAGS_OUT[FLAG_C] && FLAGS_WR == MASK_C;
  endproperty
  a_dadj_carry: assert property (p_dadj_carry) else $error("decimal adjust dropped carry");

  property p_access_bank;
    @(posedge MCLK) disable iff (!ARST_N || !CE)
    (MEM_RD && !instr_q[BIT_A] && (!$past(EXT_SET_EN) || instr_q[7:0] > ACCESS_LIMIT))
      |-> MEM_ADDR == {(instr_q[7:0] > ACCESS_LIMIT) ? ACCESS_HI_BANK : ACCESS_LO_BANK, instr_q[7:0]};
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank address wrong");

  // Enable low must hold every register, mid-instruction too
  property p_freeze;
    @(posedge MCLK) disable iff (!ARST_N)
    !CE |=> $stable(state) && $stable(QPHASE) && $stable(MEM_ADDR) && $stable(MEM_RD) && $stable(BUSY);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  c_skip_one: cover property (@(posedge MCLK) SKIP_FLUSH && !skip_two);
  c_skip_two: cover property (@(posedge MCLK) SKIP_FLUSH && skip_two);
  c_dadj:     cover property (@(posedge MCLK) WREG_WR && op_q == OP_DADJ && FLAGS_OUT[FLAG_C]);
  c_dec_mem:  cover property (@(posedge MCLK) MEM_WR && FLAGS_OUT[FLAG_Z]);
  c_greater_skip: cover property (@(posedge MCLK) SKIP_FLUSH && op_q == OP_GREATER);

endmodule : compare_skip_bcd_decrement_exec

// >>> rtl/exec_alu.sv
`timescale 1ns/10ps
module exec_alu
  import exec_pkg::*;
(
  // Operation and operands
  input  wire op_t        op,
  input  wire logic [7:0] operand,
  input  wire logic [7:0] acc,
  input  wire logic [4:0] flags_in,
  // Results
  output logic      [7:0] result,
  output logic      [4:0] flags_out,
  output logic      [4:0] flag_mask,
  output logic            less,
  output logic            greater
);

  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic       lo_carry;

  always_comb begin
    result    = operand;
    flags_out = flags_in;
    flag_mask = MASK_NONE;
    lo_sum    = {1'b0, acc[3:0]};
    hi_sum    = {1'b0, acc[7:4]};
    lo_carry  = 1'b0;
    less      = operand < acc;
    greater   = operand > acc;
    case (op)
      OP_DADJ: begin
        if (acc[3:0] > BCD_LIMIT || flags_in[FLAG_DC]) begin
          lo_sum = {1'b0, acc[3:0]} + {1'b0, BCD_FIX};
        end
        lo_carry = lo_sum[4];
        hi_sum   = {1'b0, acc[7:4]} + {4'h0, lo_carry};
        if (hi_sum > {1'b0, BCD_LIMIT} || flags_in[FLAG_C]) begin
          hi_sum = hi_sum + {1'b0, BCD_FIX};
        end
        result            = {hi_sum[3:0], lo_sum[3:0]};
        flags_out[FLAG_C] = flags_in[FLAG_C] | hi_sum[4];
        flag_mask         = MASK_C;
      end
      OP_DEC: begin
        result             = operand - 8'h01;
        flags_out[FLAG_C]  = operand != 8'h00;
        flags_out[FLAG_DC] = operand[3:0] != 4'h0;
        flags_out[FLAG_Z]  = operand == 8'h01;
        flags_out[FLAG_OV] = operand == OV_EDGE;
        flags_out[FLAG_N]  = result[7];
        flag_mask          = MASK_ALL;
      end
      default: begin
        flag_mask = MASK_NONE;
      end
    endcase
  end

endmodule : exec_alu

// >>> rtl/exec_pkg.sv
// Notes on behaviour
// - Recognise skip-if-less opcode with bank bit
// - Unsigned compare, skip when register below accumulator
// - Taken skip turns next instruction into nop
// - Skipping two-word instruction costs three cycles
// - Skip cycles idle; compare writes nothing
// - Bank bit 0 access bank, 1 uses bank_select_register
// - Decimal adjust accumulator, one cycle, carry only
// - Decrement to accumulator or back to register
// - Recognise decrement opcode with destination, bank bits
// - Decrement updates five flags, one cycle
// - Indexed offset when access, extended, address low
// - Skip-if-greater compare, unsigned, own opcode
package exec_pkg;

  localparam logic [6:0]  OPC_LESS       = 7'h30;
  localparam logic [6:0]  OPC_GREATER    = 7'h32;
  localparam logic [5:0]  OPC_DEC        = 6'h01;
  localparam logic [15:0] OPC_DADJ       = 16'h0007;
  localparam int          BIT_A          = 8;
  localparam int          BIT_D          = 9;
  localparam logic [7:0]  ACCESS_LIMIT   = 8'h5F;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0]  BCD_LIMIT      = 4'h9;
  localparam logic [3:0]  BCD_FIX        = 4'h6;
  localparam logic [7:0]  OV_EDGE        = 8'h80;
  localparam logic [3:0]  NOP_QUARTERS_1 = 4'h4;
  localparam logic [3:0]  NOP_QUARTERS_2 = 4'h8;

  localparam int          FLAG_C         = 0;
  localparam int          FLAG_DC        = 1;
  localparam int          FLAG_Z         = 2;
  localparam int          FLAG_OV        = 3;
  localparam int          FLAG_N         = 4;
  localparam logic [4:0]  MASK_NONE      = 5'h00;
  localparam logic [4:0]  MASK_C         = 5'h01;
  localparam logic [4:0]  MASK_ALL       = 5'h1F;

  typedef enum logic [4:0] {
    OP_NONE    = 5'b00001,
    OP_LESS    = 5'b00010,
    OP_GREATER = 5'b00100,
    OP_DADJ    = 5'b01000,
    OP_DEC     = 5'b10000
  } op_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_Q1   = 6'b000010,
    ST_Q2   = 6'b000100,
    ST_Q3   = 6'b001000,
    ST_Q4   = 6'b010000,
    ST_NOP  = 6'b100000
  } state_t;

  function automatic op_t decode_op(input logic [15:0] instr);
    if (instr[15:9] == OPC_LESS) begin
      return OP_LESS;
    end else if (instr[15:9] == OPC_GREATER) begin
      return OP_GREATER;
    end else if (instr[15:10] == OPC_DEC) begin
      return OP_DEC;
    end else if (instr == OPC_DADJ) begin
      return OP_DADJ;
    end else begin
      return OP_NONE;
    end
  endfunction : decode_op

  function automatic logic [11:0] eff_addr(input logic       a,
                                           input logic [7:0] f,
                                           input logic [3:0] bank,
                                           input logic       ext,
                                           input logic [11:0] base);
    if (a) begin
      return {bank, f};
    end else if (ext && f <= ACCESS_LIMIT) begin
      return 12'(base + {4'h0, f});
    end else if (f > ACCESS_LIMIT) begin
      return {ACCESS_HI_BANK, f};
    end else begin
      return {ACCESS_LO_BANK, f};
    end
  endfunction : eff_addr

endpackage : exec_pkg

// >>> testbench/compare_skip_bcd_decrement_exec_tb.sv
`timescale 1ns/10ps
module compare_skip_bcd_decrement_exec_tb;
  logic        MCLK, ARST_N, CE, INSTR_VALID, NEXT_TWO_WORD, EXT_SET_EN;
  logic [15:0] INSTR;
  logic [3:0]  BANK_SEL, QPHASE;
  logic [11:0] INDEX_BASE, MEM_ADDR, r_addr;
  logic [7:0]  WREG, MEM_RDATA, MEM_WDATA, WREG_WDATA, r_wd;
  logic [4:0]  FLAGS_IN, FLAGS_WR, FLAGS_OUT, r_fmask, r_fout;
  logic        MEM_RD, MEM_WR, WREG_WR, SKIP_FLUSH, NOP_ACTIVE, BUSY, DONE, r_qok;
  int          mismatches, num_checks, r_rd, r_wr, r_wwr, r_flush, r_nop, r_cyc, i;
  logic [7:0]  dw [4];
  logic [4:0]  df [4];
  logic [7:0]  de [4];
  logic        dc [4];

  compare_skip_bcd_decrement_exec uut (
    .MCLK(MCLK), .ARST_N(ARST_N), .CE(CE), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
    .NEXT_TWO_WORD(NEXT_TWO_WORD), .EXT_SET_EN(EXT_SET_EN), .BANK_SEL(BANK_SEL),
    .INDEX_BASE(INDEX_BASE), .WREG(WREG), .FLAGS_IN(FLAGS_IN), .MEM_ADDR(MEM_ADDR),
    .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA),
    .WREG_WR(WREG_WR), .WREG_WDATA(WREG_WDATA), .FLAGS_WR(FLAGS_WR), .FLAGS_OUT(FLAGS_OUT),
    .QPHASE(QPHASE), .SKIP_FLUSH(SKIP_FLUSH), .NOP_ACTIVE(NOP_ACTIVE), .BUSY(BUSY), .DONE(DONE)
  );

  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string msg);
    num_checks++;
    if (act !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, act, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Offers one word, then logs every strobe until DONE or 19 cycles
  task automatic run(input logic [15:0] ins, input logic [7:0] mem);
    int n;
    {r_rd, r_wr, r_wwr, r_flush, r_nop, r_cyc} = '0;
    {r_addr, r_wd, r_fmask, r_fout} = '0;
    r_qok = 1'b1;
    @(posedge MCLK);
    INSTR <= ins;
    INSTR_VALID <= 1'b1;
    MEM_RDATA <= mem;
    for (n = 1; n < 20 && r_cyc == 0; n++) begin
      @(posedge MCLK);
      if (n == 1) INSTR_VALID <= 1'b0;
      #1;
      if (n < 5 && QPHASE !== 4'h1 << (n - 1)) r_qok = 1'b0;
      if (MEM_RD === 1'b1) begin
        r_rd++;
        r_addr = MEM_ADDR;
      end
      if (MEM_WR === 1'b1) begin
        r_wr++;
        r_wd = MEM_WDATA;
      end
      if (WREG_WR === 1'b1) begin
        r_wwr++;
        r_wd = WREG_WDATA;
      end
      if (FLAGS_WR !== 5'h00) begin
        r_fmask = r_fmask | FLAGS_WR;
        r_fout = FLAGS_OUT & FLAGS_WR;
      end
      if (NOP_ACTIVE === 1'b1) r_nop++;
      if (SKIP_FLUSH === 1'b1) r_flush++;
      if (DONE === 1'b1) r_cyc = n;
    end
  endtask : run

  task automatic chk_run(input logic [11:0] a, input logic [3:0] c, nop, fl, rd);
    chk({r_addr, 4'(r_cyc), 4'(r_nop), 4'(r_flush), 4'(r_rd), 3'h0, r_qok},
        {a, c, nop, fl, rd, 4'h1}, "sequence");
  endtask : chk_run

  task automatic chk_wr(input logic [3:0] wr, wwr, input logic [7:0] wd, input logic [4:0] fm, fo);
    chk({4'(r_wr), 4'(r_wwr), r_wd, 3'h0, r_fmask, 3'h0, r_fout},
        {wr, wwr, wd, 3'h0, fm, 3'h0, fo}, "writes");
  endtask : chk_wr

  task automatic t_less;
    BANK_SEL <= 4'h3;
    WREG <= 8'h20;
    run(16'h6110, 8'h05);
    chk_run(12'h310, 4'h9, 4'h4, 4'h1, 4'h1);
    chk_wr(4'h0, 4'h0, 8'h00, 5'h00, 5'h00);
    run(16'h6080, 8'h20);
    chk_run(12'hF80, 4'h5, 4'h0, 4'h0, 4'h1);
  endtask : t_less

  task automatic t_two_word;
    NEXT_TWO_WORD <= 1'b1;
    run(16'h6110, 8'h05);
    chk_run(12'h310, 4'hD, 4'h8, 4'h1, 4'h1);
    chk_wr(4'h0, 4'h0, 8'h00, 5'h00, 5'h00);
    NEXT_TWO_WORD <= 1'b0;
  endtask : t_two_word

  task automatic t_greater;
    run(16'h6510, 8'h30);
    chk_run(12'h310, 4'h9, 4'h4, 4'h1, 4'h1);
    run(16'h6510, 8'h20);
    chk_run(12'h310, 4'h5, 4'h0, 4'h0, 4'h1);
    chk_wr(4'h0, 4'h0, 8'h00, 5'h00, 5'h00);
  endtask : t_greater

  // Flags in {N,OV,Z,DC,C}; other flags set to show only carry moves
  task automatic t_dadj;
    dw = '{8'hA5, 8'hCE, 8'h12, 8'h12};
    df = '{5'h1C, 5'h1C, 5'h02, 5'h01};
    de = '{8'h05, 8'h34, 8'h18, 8'h72};
    dc = '{1'b1, 1'b1, 1'b0, 1'b1};
    for (i = 0; i < 4; i++) begin
      WREG <= dw[i];
      FLAGS_IN <= df[i];
      run(16'h0007, 8'h00);
      chk_run(12'h000, 4'h5, 4'h0, 4'h0, 4'h0);
      chk_wr(4'h0, 4'h1, de[i], 5'h01, {4'h0, dc[i]});
    end
  endtask : t_dadj

  task automatic t_dec;
    BANK_SEL <= 4'h2;
    run(16'h0740, 8'h00);
    chk_run(12'h240, 4'h5, 4'h0, 4'h0, 4'h1);
    chk_wr(4'h1, 4'h0, 8'hFF, 5'h1F, 5'h10);
    run(16'h0540, 8'h80);
    chk_wr(4'h0, 4'h1, 8'h7F, 5'h1F, 5'h09);
    run(16'h0740, 8'h01);
    chk_wr(4'h1, 4'h0, 8'h00, 5'h1F, 5'h07);
  endtask : t_dec

  task automatic t_index;
    EXT_SET_EN <= 1'b1;
    INDEX_BASE <= 12'h200;
    run(16'h065F, 8'h10);
    chk_run(12'h25F, 4'h5, 4'h0, 4'h0, 4'h1);
    run(16'h0660, 8'h10);
    chk_run(12'hF60, 4'h5, 4'h0, 4'h0, 4'h1);
    EXT_SET_EN <= 1'b0;
    run(16'h045F, 8'h10);
    chk_run(12'h05F, 4'h5, 4'h0, 4'h0, 4'h1);
  endtask : t_index

  task automatic t_refuse;
    run(16'hFFFF, 8'h10);
    chk({4'(r_cyc), 4'(r_rd), 4'(r_wr), 4'(r_wwr)}, 16'h0000, "refused");
  endtask : t_refuse

  // Enable dropped in the read quarter; the decrement must resume intact
  task automatic t_freeze;
    @(posedge MCLK);
    INSTR <= 16'h0740;
    INSTR_VALID <= 1'b1;
    MEM_RDATA <= 8'h10;
    @(posedge MCLK);
    INSTR_VALID <= 1'b0;
    @(posedge MCLK);
    CE <= 1'b0;
    repeat (3) @(posedge MCLK);
    #1;
    chk({MEM_ADDR, QPHASE, MEM_RD, BUSY, DONE}, {12'h240, 4'h2, 1'b1, 1'b1, 1'b0}, "frozen");
    CE <= 1'b1;
    repeat (2) @(posedge MCLK);
    #1;
    chk({MEM_WR, MEM_WDATA, FLAGS_OUT}, {1'b1, 8'h0F, 5'h01}, "resumed");
    @(posedge MCLK);
    #1;
    chk({DONE, BUSY}, {1'b1, 1'b0}, "freeze end");
  endtask : t_freeze

  initial begin
    #50000;
    mismatches++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    {ARST_N, INSTR_VALID, NEXT_TWO_WORD, EXT_SET_EN, INSTR, BANK_SEL} = '0;
    {INDEX_BASE, WREG, FLAGS_IN, MEM_RDATA} = '0;
    CE = 1'b1;
    mismatches = 0;
    num_checks = 0;
    repeat (5) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    #1;
    chk({BUSY, DONE, MEM_RD, MEM_WR, WREG_WR, SKIP_FLUSH, NOP_ACTIVE, QPHASE}, '0, "reset");
    t_less();
    t_two_word();
    t_greater();
    t_dadj();
    t_dec();
    t_index();
    t_freeze();
    t_refuse();
    stop_test();
  end
endmodule : compare_skip_bcd_decrement_exec_tb
